// ### core/eprom_mem_fn.sv
// memory-function logic of an add-only eprom token behind the slot layer
// Operation
// - data memory: four pages of 32 bytes
// - byte held in scratchpad, crc-checked, then programmed
// - separate 64-bit status memory, own commands
// - write-protect bit blocks programming its page
// - redirection bytes stored only, never acted on
// - programming only clears bits to zero
// - writes one byte at a time, master programs
// - reads run to field end or reset
// - all bytes serialised least significant bit first
// - command f0h starts sequential data read
// - crc of command and address returned
// - crc of read data after last byte
// - ones on every read slot after crc
// - reset before end aborts without crc
// - write crc: full first, address+data later
// - program pulse ands scratchpad into byte, then readback
// - after verify, increment address, preload crc
// - readback shows and of all written bytes
`timescale 1ns/1ps
`default_nettype none
module eprom_mem_fn
  import eprom_fn_pkg::*;
#(
  parameter int DATA_N = DATA_BYTES,
  parameter int PAGE_N = PAGE_BYTES,
  parameter int STAT_N = STAT_BYTES
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic bus_reset,
  input  wire logic rom_done,
  input  wire logic wr_slot,
  input  wire logic wr_bit,
  input  wire logic rd_slot,
  output var  logic rd_bit,
  input  wire logic prog_detect,
  output var  logic func_active
);
  localparam int DAW   = $clog2(DATA_N);
  localparam int SAW   = $clog2(STAT_N);
  localparam int PAW   = $clog2(PAGE_N);
  localparam int PAGES = DATA_N / PAGE_N;

  // elaboration check: power-of-two fields, two to eight pages
  if (DATA_N % PAGE_N != 0 || PAGES > 8 || STAT_N < REDIR_LAST + 1 ||
      (1 << DAW) != DATA_N || (1 << SAW) != STAT_N ||
      (1 << PAW) != PAGE_N || PAGES < 2) begin
    $error("eprom_mem_fn: unsupported geometry");
  end

  fn_state_t  state_r;
  fn_state_t  state_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic [7:0] crc_r;
  logic [7:0] crc_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       prog_lvl;
  logic       prog_d_r;
  // byte array of the data field; separate status array
  logic [7:0] mem_r  [DATA_N];
  logic [7:0] stat_r [STAT_N];

  level_sync3 u_prog_sync (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .async_in  (prog_detect),
    .level_out (prog_lvl)
  );

  wire              prog_fire = prog_lvl & ~prog_d_r;
  wire              is_stat   = (cmd_r == CMD_READ_STAT) |
                                (cmd_r == CMD_WRITE_STA);
  wire              is_read   = (cmd_r == CMD_READ_MEM) |
                                (cmd_r == CMD_READ_STAT);
  wire [15:0]       addr_inc  = addr_r + ADDR_STEP;
  wire [DAW-1:0]    didx      = addr_r[DAW-1:0];
  wire [SAW-1:0]    sidx      = addr_r[SAW-1:0];
  wire [DAW-1:0]    didx_inc  = addr_inc[DAW-1:0];
  wire [SAW-1:0]    sidx_inc  = addr_inc[SAW-1:0];
  wire [DAW-PAW-1:0] page     = didx[DAW-1:PAW];
  wire [7:0]        cur_byte  = is_stat ? stat_r[sidx] : mem_r[didx];
  wire [7:0]        next_byte = is_stat ? stat_r[sidx_inc] : mem_r[didx_inc];
  wire              is_last   = is_stat ? (&sidx) : (&didx);
  // page locked once its status bit is programmed to zero
  wire              wp_hit    = ~is_stat & ~stat_r[WP_BYTE][page];
  // programming ands scratchpad into the stored byte
  // a locked page keeps its previous contents
  wire [7:0]        prog_val  = wp_hit ? cur_byte : (cur_byte & rx_r);
  wire              prog_go   = (state_r == ST_WAIT_PROG) & prog_fire &
                                ~bus_reset;
  wire              cmd_ok    = is_cmd(rx_nxt);
  wire              byte_in   = wr_slot & (cnt_r == LAST_BIT);
  wire              byte_out  = rd_slot & (cnt_r == LAST_BIT);

  function automatic logic is_cmd(input logic [7:0] c);
    return (c == CMD_READ_MEM) | (c == CMD_READ_STAT) |
           (c == CMD_WRITE_MEM) | (c == CMD_WRITE_STA);
  endfunction

  // bits go out from tx_r[0], lsb first
  assign rd_bit      = tx_r[0];
  assign func_active = (state_r != ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    rx_nxt    = rx_r;
    tx_nxt    = tx_r;
    crc_nxt   = crc_r;
    cmd_nxt   = cmd_r;
    addr_nxt  = addr_r;
    cnt_nxt   = cnt_r;
    if (bus_reset) begin
      // reset aborts any sequence, no trailing crc
      state_nxt = ST_IDLE;
      cnt_nxt   = 3'h0;
      tx_nxt    = ERASED_BYTE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (rom_done) begin
            state_nxt = ST_CMD;
            cnt_nxt   = 3'h0;
            crc_nxt   = CRC_INIT;
          end
        end
        ST_CMD, ST_ALO, ST_AHI, ST_WR_DATA: begin
          if (wr_slot) begin
            // received bits enter at the top, lsb first
            rx_nxt  = {wr_bit, rx_r[7:1]};
            cnt_nxt = cnt_r + 3'h1;
          end
          if (byte_in) begin
            crc_nxt = crc_byte(crc_r, rx_nxt);
            case (state_r)
              ST_CMD: begin
                cmd_nxt   = rx_nxt;
                state_nxt = cmd_ok ? ST_ALO : ST_HALT;
              end
              ST_ALO: begin
                addr_nxt[7:0] = rx_nxt;
                state_nxt     = ST_AHI;
              end
              ST_AHI: begin
                addr_nxt[15:8] = rx_nxt;
                if (is_read) begin
                  // header crc of command and address
                  tx_nxt    = crc_byte(crc_r, rx_nxt);
                  state_nxt = ST_HDR_CRC;
                end else begin
                  state_nxt = ST_WR_DATA;
                end
              end
              default: begin
                // scratchpad byte answered by its crc
                tx_nxt    = crc_byte(crc_r, rx_nxt);
                state_nxt = ST_WR_CRC;
              end
            endcase
          end
        end
        ST_HDR_CRC, ST_RD_DATA, ST_END_CRC, ST_WR_CRC, ST_VERIFY,
        ST_ONES: begin
          if (rd_slot) begin
            // shifting in ones leaves all-ones once a byte is out
            tx_nxt  = {1'b1, tx_r[7:1]};
            cnt_nxt = cnt_r + 3'h1;
          end
          if (byte_out) begin
            case (state_r)
              ST_HDR_CRC: begin
                // sequential read starts at the given address
                tx_nxt    = cur_byte;
                crc_nxt   = crc_byte(CRC_INIT, cur_byte);
                state_nxt = ST_RD_DATA;
              end
              ST_RD_DATA: begin
                if (is_last) begin
                  // crc of all bytes read follows the last one
                  tx_nxt    = crc_r;
                  state_nxt = ST_END_CRC;
                end else begin
                  // continue to the end of the field
                  addr_nxt = addr_inc;
                  tx_nxt   = next_byte;
                  crc_nxt  = crc_byte(crc_r, next_byte);
                end
              end
              ST_WR_CRC: state_nxt = ST_WAIT_PROG;
              ST_VERIFY: begin
                if (is_last) begin
                  state_nxt = ST_ONES;
                end else begin
                  // next address, its low byte seeds the crc
                  addr_nxt  = addr_inc;
                  crc_nxt   = addr_inc[7:0];
                  state_nxt = ST_WR_DATA;
                end
              end
              ST_END_CRC: state_nxt = ST_ONES;
              default: state_nxt = state_r;
            endcase
          end
        end
        ST_WAIT_PROG: begin
          if (prog_fire) begin
            // readback of the byte just programmed
            tx_nxt    = prog_val;
            cnt_nxt   = 3'h0;
            state_nxt = ST_VERIFY;
          end
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r  <= ST_IDLE;
      rx_r     <= ERASED_BYTE;
      tx_r     <= ERASED_BYTE;
      crc_r    <= CRC_INIT;
      cmd_r    <= CMD_READ_MEM;
      addr_r   <= '0;
      cnt_r    <= 3'h0;
      prog_d_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      rx_r     <= rx_nxt;
      tx_r     <= tx_nxt;
      crc_r    <= crc_nxt;
      cmd_r    <= cmd_nxt;
      addr_r   <= addr_nxt;
      cnt_r    <= cnt_nxt;
      prog_d_r <= prog_lvl;
    end
  end

  // one byte programmed per program pulse
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DATA_N; i++) begin
        mem_r[i] <= ERASED_BYTE;
      end
      for (int j = 0; j < STAT_N; j++) begin
        stat_r[j] <= (j <= REDIR_LAST) ? ERASED_BYTE : FACTORY_BYTE;
      end
    end else if (prog_go) begin
      // status bytes are programmed like data; only byte WP_BYTE is decoded, as page write-protect bits
      if (is_stat) begin
        stat_r[sidx] <= prog_val;
      end else begin
        mem_r[didx] <= prog_val;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_ones_after_crc: assert property (
    state_r == ST_ONES |-> rd_bit)
    else $error("read slot after crc is not one");

  chk_protect_holds: assert property (
    prog_go && wp_hit |=> cur_byte == $past(cur_byte))
    else $error("protected page byte changed");

  chk_add_only_bits: assert property (
    prog_go |=> (cur_byte & ~$past(cur_byte)) == 8'h00)
    else $error("programming set a bit to one");

  chk_verify_and: assert property (
    prog_go && !wp_hit |=> cur_byte == ($past(cur_byte) & $past(rx_r))
                           && tx_r == cur_byte)
    else $error("readback is not the and of written bytes");

  chk_addr_step: assert property (
    state_r == ST_VERIFY && byte_out && !is_last && !bus_reset
    |=> addr_r == $past(addr_inc) && crc_r == $past(addr_inc[7:0])
        && state_r == ST_WR_DATA)
    else $error("address increment or crc preload wrong");

  chk_hdr_crc_out: assert property (
    state_r == ST_AHI && byte_in && is_cmd(cmd_r) && is_read && !bus_reset
    |=> state_r == ST_HDR_CRC && tx_r == crc_byte($past(crc_r), $past(rx_nxt)))
    else $error("header crc not presented");

  chk_reset_abort: assert property (
    bus_reset |=> state_r == ST_IDLE ##0 rd_bit)
    else $error("reset pulse did not abort the sequence");

  chk_end_crc_last: assert property (
    state_r == ST_RD_DATA && byte_out && is_last && !bus_reset
    |=> state_r == ST_END_CRC && tx_r == $past(crc_r))
    else $error("end crc not sent after last byte");

  chk_lsb_first: assert property (
    state_r == ST_RD_DATA && rd_slot && cnt_r != LAST_BIT && !bus_reset
    |=> rd_bit == $past(tx_r[1]))
    else $error("read bits not lsb first");

  chk_rd_first_byte: assert property (
    state_r == ST_HDR_CRC && byte_out && !bus_reset
    |=> state_r == ST_RD_DATA && tx_r == cur_byte)
    else $error("first data byte not loaded after header crc");

  chk_rd_advance: assert property (
    state_r == ST_RD_DATA && byte_out && !is_last && !bus_reset
    |=> state_r == ST_RD_DATA && addr_r == $past(addr_inc)
        && tx_r == cur_byte)
    else $error("sequential read did not advance");

  chk_wr_crc_out: assert property (
    state_r == ST_WR_DATA && byte_in && !bus_reset
    |=> state_r == ST_WR_CRC
        && tx_r == crc_byte($past(crc_r), $past(rx_nxt)))
    else $error("write crc not presented");

  chk_prog_one_byte: assert property (
    prog_go |=> state_r == ST_VERIFY && !prog_go)
    else $error("program pulse did not end in a single verify");

  cov_read_to_ones: cover property (
    state_r == ST_END_CRC ##1 state_r == ST_ONES);
  cov_write_verify: cover property (
    prog_go && !wp_hit ##1 state_r == ST_VERIFY);
  cov_protected_try: cover property (prog_go && wp_hit);
  cov_second_pass: cover property (
    state_r == ST_VERIFY ##1 state_r == ST_WR_DATA);
endmodule
`default_nettype wire

// ### core/eprom_fn_pkg.sv
// constants shared by the add-only eprom memory-function logic
package eprom_fn_pkg;
  localparam int          DATA_BYTES    = 128;
  localparam int          PAGE_BYTES    = 32;
  localparam int          STAT_BYTES    = 8;
  localparam logic [7:0]  CMD_READ_MEM  = 8'hf0;
  localparam logic [7:0]  CMD_READ_STAT = 8'haa;
  localparam logic [7:0]  CMD_WRITE_MEM = 8'h0f;
  localparam logic [7:0]  CMD_WRITE_STA = 8'h55;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [7:0]  FACTORY_BYTE  = 8'h00;
  localparam logic [7:0]  CRC_POLY_REV  = 8'h8c;
  localparam logic [7:0]  CRC_INIT      = 8'h00;
  localparam int          WP_BYTE       = 0;
  localparam int          REDIR_FIRST   = 1;
  localparam int          REDIR_LAST    = 4;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [15:0] ADDR_STEP     = 16'h0001;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ALO, ST_AHI, ST_HDR_CRC, ST_RD_DATA, ST_END_CRC,
    ST_ONES, ST_WR_DATA, ST_WR_CRC, ST_WAIT_PROG, ST_VERIFY, ST_HALT
  } fn_state_t;

  // one lsb-first step of the x^8+x^5+x^4+1 crc
  function automatic logic [7:0] crc_byte(input logic [7:0] crc,
                                          input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ CRC_POLY_REV;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction
endpackage

// ### core/level_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module level_sync3 (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output var  logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign level_out = level_r;
endmodule
`default_nettype wire

// ### verif/master_bfm.sv
// bus master model issuing slots and program pulses to the memory logic
`timescale 1ns/1ps
`default_nettype none
module master_bfm #(
  parameter int PROG_CYC = 40
) (
  input  wire logic sys_clk,
  output var  logic bus_reset,
  output var  logic rom_done,
  output var  logic wr_slot,
  output var  logic wr_bit,
  output var  logic rd_slot,
  input  wire logic rd_bit,
  output var  logic prog_detect
);
  initial begin
    {bus_reset, rom_done, wr_slot, wr_bit, rd_slot, prog_detect} = '0;
  end
  task automatic start_fn();
    @(posedge sys_clk) rom_done <= 1'b1;
    @(posedge sys_clk) rom_done <= 1'b0;
  endtask
  task automatic line_reset();
    @(posedge sys_clk) bus_reset <= 1'b1;
    @(posedge sys_clk) bus_reset <= 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      wr_slot <= 1'b1;
      wr_bit  <= b[i];
    end
    @(posedge sys_clk);
    wr_slot <= 1'b0;
    wr_bit  <= ~b[7];
  endtask
  task automatic recv_byte(output logic [7:0] b);
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk) b[i] = rd_bit;
      @(posedge sys_clk) rd_slot <= 1'b1;
      @(posedge sys_clk) rd_slot <= 1'b0;
    end
  endtask
  task automatic prog_pulse();
    @(posedge sys_clk) prog_detect <= 1'b1;
    repeat (PROG_CYC) @(posedge sys_clk);
    prog_detect <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ### verif/add_only_eprom_memory_functions_tb.sv
// self-checking bench for the add-only eprom memory-function logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) begin \
      num_errors++; \
      $display("CHECK FAILED at %0t: %h vs %h", $time, a, b); \
    end \
  end
module add_only_eprom_memory_functions_tb
  import eprom_fn_pkg::*;
;
  logic       sys_clk, sys_rst, bus_reset, rom_done, wr_slot, wr_bit;
  logic       rd_slot, rd_bit, prog_detect, func_active;
  int         num_errors = 0;
  int         n_tests    = 0;
  logic [31:0] seed      = 32'hb696f711;
  logic [7:0] ref_mem  [DATA_BYTES];
  logic [7:0] ref_stat [STAT_BYTES];

  eprom_mem_fn i_eprom_mem_fn (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus_reset(bus_reset), .rom_done(rom_done), .wr_slot(wr_slot),
    .wr_bit(wr_bit), .rd_slot(rd_slot), .rd_bit(rd_bit),
    .prog_detect(prog_detect), .func_active(func_active));
  master_bfm i_master_bfm (.sys_clk(sys_clk), .bus_reset(bus_reset),
    .rom_done(rom_done), .wr_slot(wr_slot), .wr_bit(wr_bit),
    .rd_slot(rd_slot), .rd_bit(rd_bit), .prog_detect(prog_detect));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
    end
    return c;
  endfunction

  task automatic hdr(input logic [7:0] cmd, input logic [15:0] a,
                     output logic [7:0] c);
    i_master_bfm.start_fn();
    i_master_bfm.send_byte(cmd);
    i_master_bfm.send_byte(a[7:0]);
    i_master_bfm.send_byte(a[15:8]);
    c = crc_step(crc_step(crc_step(8'h00, cmd), a[7:0]), a[15:8]);
  endtask

  task automatic rd_field(input logic [7:0] cmd, input logic [15:0] a);
    logic [7:0] c, got, e;
    int last;
    last = (cmd == CMD_READ_MEM) ? DATA_BYTES - 1 : STAT_BYTES - 1;
    hdr(cmd, a, c);
    i_master_bfm.recv_byte(got);
    `CHK(got, c)
    c = 8'h00;
    for (int i = a & last; i <= last; i++) begin
      e = (cmd == CMD_READ_MEM) ? ref_mem[i] : ref_stat[i];
      i_master_bfm.recv_byte(got);
      `CHK(got, e)
      c = crc_step(c, e);
    end
    i_master_bfm.recv_byte(got);
    `CHK(got, c)
    i_master_bfm.recv_byte(got);
    `CHK(got, 8'hff)
    i_master_bfm.line_reset();
  endtask

  task automatic wr_seq(input logic [7:0] cmd, input logic [15:0] a,
                        input logic [7:0] d0, input int n);
    logic [7:0] c, got, d, e;
    logic       lock;
    int last, i;
    last = (cmd == CMD_WRITE_MEM) ? DATA_BYTES - 1 : STAT_BYTES - 1;
    hdr(cmd, a, c);
    i = a & last;
    for (int k = 0; k < n && i <= last; k++) begin
      d = (k == 0) ? d0 : 8'(rnd());
      if (k > 0) c = i[7:0];
      i_master_bfm.send_byte(d);
      c = crc_step(c, d);
      i_master_bfm.recv_byte(got);
      `CHK(got, c)
      i_master_bfm.prog_pulse();
      lock = (cmd == CMD_WRITE_MEM) && !ref_stat[WP_BYTE][i / PAGE_BYTES];
      e = (cmd == CMD_WRITE_MEM) ? ref_mem[i] : ref_stat[i];
      e = lock ? e : (e & d);
      if (cmd == CMD_WRITE_MEM) ref_mem[i] = e;
      else ref_stat[i] = e;
      i_master_bfm.recv_byte(got);
      `CHK(got, e)
      i++;
    end
    if (i > last) begin
      i_master_bfm.recv_byte(got);
      `CHK(got, 8'hff)
    end
    i_master_bfm.line_reset();
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end

  initial begin
    logic [7:0] c, got;
    sys_rst = 1'b1;
    foreach (ref_mem[i]) ref_mem[i] = ERASED_BYTE;
    foreach (ref_stat[i]) ref_stat[i] = (i <= REDIR_LAST) ? 8'hff : 8'h00;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    `CHK(rd_bit, 1'b1)
    `CHK(func_active, 1'b0)
    // slots before the rom step are ignored
    i_master_bfm.send_byte(CMD_READ_MEM);
    @(negedge sys_clk);
    `CHK(func_active, 1'b0)
    // unknown command gives ones only
    i_master_bfm.start_fn();
    i_master_bfm.send_byte(8'h3c);
    i_master_bfm.recv_byte(got);
    `CHK(got, 8'hff)
    i_master_bfm.line_reset();
    rd_field(CMD_READ_MEM, 16'h0078);
    repeat (4) wr_seq(CMD_WRITE_MEM, 16'(rnd() & 32'h7f), 8'(rnd()), 3);
    wr_seq(CMD_WRITE_MEM, 16'h0005, 8'h0f, 1);
    wr_seq(CMD_WRITE_MEM, 16'h0005, 8'h3c, 1);
    wr_seq(CMD_WRITE_MEM, 16'h007e, 8'h5a, 3);
    wr_seq(CMD_WRITE_STA, 16'h0000, 8'hfe, 1);
    wr_seq(CMD_WRITE_MEM, 16'h0006, 8'h00, 1);
    // redirect page one to two, no effect
    wr_seq(CMD_WRITE_STA, 16'h0002, 8'hfd, 1);
    wr_seq(CMD_WRITE_MEM, 16'h0021, 8'h81, 2);
    hdr(CMD_READ_MEM, 16'h0010, c);
    repeat (3) i_master_bfm.recv_byte(got);
    i_master_bfm.line_reset();
    @(negedge sys_clk);
    `CHK(func_active, 1'b0)
    `CHK(rd_bit, 1'b1)
    rd_field(CMD_READ_STAT, 16'h0000);
    rd_field(CMD_READ_MEM, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
